//--- logic/pin_int_defines.svh
// Constants of the pin interrupt unit: register indices, reset values, field positions
`ifndef PIN_INT_DEFINES_SVH
`define PIN_INT_DEFINES_SVH

// ****************************************
// Sizes
// ****************************************
`define PI_CHANNELS 8
`define PI_PORTS 4
`define PI_PORT_BITS 8
`define PI_ADDR_W 12
`define PI_DATA_W 32

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define PI_IDX_TRIG_TYPE 8'he9
`define PI_IDX_NEG_EN 8'hea
`define PI_IDX_POS_EN 8'heb
`define PI_IDX_FLAGS 8'hec
`define PI_IDX_STATUS 8'hf0
`define PI_IDX_MASK 8'hf1
`define PI_IDX_SRC0 8'hf9
`define PI_IDX_SRC1 8'hfa
`define PI_IDX_SRC2 8'hfb
`define PI_IDX_SRC3 8'hfc
`define PI_IDX_SRC4 8'hfd
`define PI_IDX_SRC5 8'hfe
`define PI_IDX_SRC6 8'hff
`define PI_IDX_SRC7 8'hf7

// ****************************************
// Reset values
// ****************************************
`define PI_RST_TRIG_TYPE 8'h34
`define PI_RST_ZERO8 8'h00
`define PI_RST_ZERO32 32'h0000_0000

// ****************************************
// Source select fields
// ****************************************
`define PI_SEL_PORT_MSB 6
`define PI_SEL_PORT_LSB 4
`define PI_SEL_BIT_MSB 2
`define PI_SEL_BIT_LSB 0
`define PI_SEL_WMASK 8'h77

`endif

//--- logic/pin_int_pkg.sv
// Types of the pin interrupt unit
`default_nettype none
`include "pin_int_defines.svh"
package pin_int_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [`PI_DATA_W-1:0] word_t;
  typedef logic [`PI_PORTS*`PI_PORT_BITS-1:0] pins_t;

  typedef struct packed {
    logic prevLevel;
    logic primed;
    logic flag;
    logic setPulse;
  } chan_state_t;

  typedef struct packed {
    pins_t pinSync1;
    pins_t pinSync2;
    byte_t trigType;
    byte_t negEn;
    byte_t posEn;
    logic [`PI_CHANNELS-1:0][7:0] srcSel;
    byte_t status;
    byte_t mask;
    byte_t flagWrite;
    byte_t flagWdata;
    word_t prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic pinIntReq;
  } unit_state_t;

endpackage
`default_nettype wire

//--- logic/pin_int_channel.sv
// One pin interrupt channel: level or edge detection and its flag
`timescale 1ns/1ps
`default_nettype none
module pin_int_channel
  import pin_int_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Selected source
  input wire logic srcLevel,
  input wire logic srcValid,
  // Configuration
  input wire logic edgeMode,
  input wire logic negEnable,
  input wire logic posEnable,
  // Software write of the flag
  input wire logic flagWrite,
  input wire logic flagWriteData,
  // Results
  output logic flag,
  output logic setPulse
);

  chan_state_t st_r;
  chan_state_t st_nxt;

  always_comb begin
    logic fall;
    logic rise;
    logic hit;
    fall = st_r.primed & srcValid & st_r.prevLevel & ~srcLevel;
    rise = st_r.primed & srcValid & ~st_r.prevLevel & srcLevel;
    hit = 1'b0;
    st_nxt = st_r;
    st_nxt.prevLevel = srcLevel;
    st_nxt.primed = srcValid;
    if (!edgeMode) begin
      // Level mode: flag follows the active level, software cannot write it
      hit = srcValid & ((negEnable & ~srcLevel) | (posEnable & srcLevel));
      st_nxt.flag = hit;
    end else begin
      // Edge mode: flag is set by an edge, software may write it; set wins
      hit = (negEnable & fall) | (posEnable & rise);
      if (flagWrite) begin
        st_nxt.flag = flagWriteData;
      end
      if (hit) begin
        st_nxt.flag = 1'b1;
      end
    end
    st_nxt.setPulse = st_nxt.flag & ~st_r.flag;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag = st_r.flag;
  assign setPulse = st_r.setPulse;

endmodule // pin_int_channel
`default_nettype wire

//--- logic/pin_interrupt_unit.sv
// Eight-channel pin interrupt unit with APB register access
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pin_int_defines.svh"
module pin_interrupt_unit
  import pin_int_pkg::*;
#(
  parameter int NUM_CHANNELS = `PI_CHANNELS,
  parameter int NUM_PORTS = `PI_PORTS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PI_ADDR_W-1:0] paddr,
  input wire logic [`PI_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`PI_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins, port p bit b at index 8*p+b
  input wire logic [`PI_PORTS*`PI_PORT_BITS-1:0] pinLevels,
  // Interrupt outputs
  output logic pinIntReq,
  output logic irq
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (NUM_CHANNELS != `PI_CHANNELS) begin : gChanCheck
    $error("pin_interrupt_unit serves exactly eight channels");
  end
  if (NUM_PORTS < 1 || NUM_PORTS > `PI_PORTS) begin : gPortCheck
    $error("pin_interrupt_unit serves one to four ports");
  end

  // ****************************************
  // Functions
  // ****************************************

  // Index of the source-select register of a channel
  function automatic byte_t srcIndex(input int ch);
    byte_t idx;
    unique case (ch)
      0: idx = `PI_IDX_SRC0;
      1: idx = `PI_IDX_SRC1;
      2: idx = `PI_IDX_SRC2;
      3: idx = `PI_IDX_SRC3;
      4: idx = `PI_IDX_SRC4;
      5: idx = `PI_IDX_SRC5;
      6: idx = `PI_IDX_SRC6;
      default: idx = `PI_IDX_SRC7;
    endcase
    return idx;
  endfunction

  // Port code of a source select lies on an existing port
  function automatic logic srcValidOf(input byte_t sel);
    logic [2:0] port;
    port = sel[`PI_SEL_PORT_MSB:`PI_SEL_PORT_LSB];
    return ({29'h0000_0000, port} < NUM_PORTS);
  endfunction

  // Level of the pin that a source select names
  function automatic logic srcLevelOf(input pins_t pins, input byte_t sel);
    logic [2:0] port;
    logic [2:0] bitSel;
    port = sel[`PI_SEL_PORT_MSB:`PI_SEL_PORT_LSB];
    bitSel = sel[`PI_SEL_BIT_MSB:`PI_SEL_BIT_LSB];
    return pins[{port[1:0], bitSel}];
  endfunction

  // Register index is mapped
  function automatic logic isMapped(input byte_t idx);
    logic hit;
    hit = 1'b0;
    if (idx == `PI_IDX_TRIG_TYPE || idx == `PI_IDX_NEG_EN) begin
      hit = 1'b1;
    end
    if (idx == `PI_IDX_POS_EN || idx == `PI_IDX_FLAGS) begin
      hit = 1'b1;
    end
    if (idx == `PI_IDX_STATUS || idx == `PI_IDX_MASK) begin
      hit = 1'b1;
    end
    for (int c = 0; c < `PI_CHANNELS; c++) begin
      if (idx == srcIndex(c)) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ****************************************
  // State
  // ****************************************
  unit_state_t st_r;
  unit_state_t st_nxt;

  logic [`PI_CHANNELS-1:0] chanFlag;
  logic [`PI_CHANNELS-1:0] chanSet;
  logic [`PI_CHANNELS-1:0] chanLevel;
  logic [`PI_CHANNELS-1:0] chanValid;

  // ****************************************
  // Channels
  // ****************************************
  for (genvar g = 0; g < `PI_CHANNELS; g++) begin : gChan
    assign chanLevel[g] = srcLevelOf(st_r.pinSync2, st_r.srcSel[g]);
    assign chanValid[g] = srcValidOf(st_r.srcSel[g]);

    pin_int_channel uChan (
      .clock(clock),
      .nrst(nrst),
      .srcLevel(chanLevel[g]),
      .srcValid(chanValid[g]),
      .edgeMode(st_r.trigType[g]),
      .negEnable(st_r.negEn[g]),
      .posEnable(st_r.posEn[g]),
      .flagWrite(st_r.flagWrite[g]),
      .flagWriteData(st_r.flagWdata[g]),
      .flag(chanFlag[g]),
      .setPulse(chanSet[g])
    );
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic apbSetup;
    logic apbAccess;
    logic aligned;
    logic hit;
    byte_t idx;
    byte_t wbyte;
    byte_t rbyte;
    byte_t stsClear;

    st_nxt = st_r;
    apbSetup = psel & ~penable;
    apbAccess = psel & penable & st_r.pready;
    aligned = (paddr[1:0] == 2'b00) && (paddr[`PI_ADDR_W-1:10] == 2'b00);
    idx = paddr[9:2];
    hit = aligned & isMapped(idx);
    wbyte = pwdata[7:0];
    rbyte = `PI_RST_ZERO8;
    stsClear = `PI_RST_ZERO8;

    // Pin synchroniser
    st_nxt.pinSync1 = pinLevels;
    st_nxt.pinSync2 = st_r.pinSync1;

    // Flag write strobes last one cycle
    st_nxt.flagWrite = `PI_RST_ZERO8;

    // Read data
    if (idx == `PI_IDX_TRIG_TYPE) begin
      rbyte = st_r.trigType;
    end
    if (idx == `PI_IDX_NEG_EN) begin
      rbyte = st_r.negEn;
    end
    if (idx == `PI_IDX_POS_EN) begin
      rbyte = st_r.posEn;
    end
    if (idx == `PI_IDX_FLAGS) begin
      rbyte = chanFlag;
    end
    if (idx == `PI_IDX_STATUS) begin
      rbyte = st_r.status;
    end
    if (idx == `PI_IDX_MASK) begin
      rbyte = st_r.mask;
    end
    for (int c = 0; c < `PI_CHANNELS; c++) begin
      if (idx == srcIndex(c)) begin
        rbyte = st_r.srcSel[c];
      end
    end

    // APB answer: one access cycle, no wait states
    if (apbSetup) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = ~hit;
      st_nxt.prdata = (hit && !pwrite) ? {24'h00_0000, rbyte} : `PI_RST_ZERO32;
    end else begin
      st_nxt.pready = 1'b0;
      st_nxt.pslverr = 1'b0;
    end

    // Register writes
    if (apbAccess && pwrite && hit && pstrb[0]) begin
      if (idx == `PI_IDX_TRIG_TYPE) begin
        st_nxt.trigType = wbyte;
      end
      if (idx == `PI_IDX_NEG_EN) begin
        st_nxt.negEn = wbyte;
      end
      if (idx == `PI_IDX_POS_EN) begin
        st_nxt.posEn = wbyte;
      end
      if (idx == `PI_IDX_FLAGS) begin
        st_nxt.flagWrite = st_r.trigType;
        st_nxt.flagWdata = wbyte;
      end
      if (idx == `PI_IDX_STATUS) begin
        stsClear = wbyte;
      end
      if (idx == `PI_IDX_MASK) begin
        st_nxt.mask = wbyte;
      end
      for (int c = 0; c < `PI_CHANNELS; c++) begin
        if (idx == srcIndex(c)) begin
          st_nxt.srcSel[c] = wbyte & `PI_SEL_WMASK;
        end
      end
    end

    // Sticky status, set wins over write-one clear
    st_nxt.status = (st_r.status & ~stsClear) | chanSet;

    // Interrupt outputs
    st_nxt.pinIntReq = |chanFlag;
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.trigType <= `PI_RST_TRIG_TYPE;
      st_r.negEn <= `PI_RST_ZERO8;
      st_r.posEn <= `PI_RST_ZERO8;
      st_r.srcSel <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign pinIntReq = st_r.pinIntReq;
  assign irq = st_r.irq;

endmodule // pin_interrupt_unit
`default_nettype wire

//--- sim/pin_int_unit_asserts.sv
// Port checker of the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pin_int_unit_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and interrupts
  input wire logic [31:0] pinLevels,
  input wire logic pinIntReq,
  input wire logic irq
);
  logic trigWr_r;
  logic mapped;
  assign mapped = paddr[1:0] == 2'b00 &&
    paddr inside {12'h3a4, 12'h3a8, 12'h3ac, 12'h3b0, 12'h3c0, 12'h3c4, 12'h3dc, [12'h3e4:12'h3fc]};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      trigWr_r <= 1'b0;
    end else if (psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h3a4) begin
      trigWr_r <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ********
  // Assertions
  // ********
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr with data or without pready");
  map_err_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  trig_reset_a: assert property (pready && !pwrite && paddr == 12'h3a4 && !trigWr_r |-> prdata == 32'h34)
    else $error("trigger type not at reset value");
  req_quiet_a: assert property ((!psel && $stable(pinLevels)) [*6] |=> $stable(pinIntReq))
    else $error("pinIntReq moved with quiet pins");
  irq_quiet_a: assert property ((!psel && $stable(pinLevels)) [*6] |=> $stable(irq))
    else $error("irq moved with quiet pins");
endmodule // pin_int_unit_asserts
bind pin_interrupt_unit pin_int_unit_asserts i_pin_int_unit_asserts (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinLevels(pinLevels), .pinIntReq(pinIntReq), .irq(irq));
`default_nettype wire

//--- sim/pin_drive_model.sv
// Model of the port pins around the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pin_drive_model (
  // Clock
  input wire logic clock,
  // Wanted levels and answer speed
  input wire logic [31:0] want,
  input wire logic slow,
  // Pins
  output logic [31:0] pinLevels
);
  logic [31:0] stage_r;
  // ********
  // Pins follow the wanted levels one or two cycles late
  // ********
  always_ff @(posedge clock) begin
    stage_r <= want;
    pinLevels <= slow ? stage_r : want;
  end
endmodule // pin_drive_model
`default_nettype wire

//--- sim/test_pin_interrupt_unit.sv
// Testbench of the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module test_pin_interrupt_unit;
  import pin_int_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  word_t pwdata = 32'h0;
  word_t prdata;
  word_t rdat;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, pinIntReq, irq, rerr;
  logic slow = 1'b0;
  pins_t pinLevels;
  pins_t want = 32'h0;
  int err_count = 0;
  int num_checks = 0;
  always #25 clock = ~clock;
  pin_drive_model i_pin_drive_model (.clock(clock), .want(want), .slow(slow), .pinLevels(pinLevels));
  pin_interrupt_unit i_pin_interrupt_unit (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinLevels(pinLevels), .pinIntReq(pinIntReq), .irq(irq));
  // ********
  // Shared tasks
  // ********
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      complete_run;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rdat, exp);
  endtask
  task wt(input int k);
    repeat (k) @(posedge clock);
  endtask
  // ********
  // Scenarios
  // ********
  task reset_values;
    rc(12'h3a4, 32'h34);
    rc(12'h3a8, 32'h0);
    rc(12'h3ac, 32'h0);
    rc(12'h3b0, 32'h0);
    rc(12'h3dc, 32'h0);
    for (int i = 0; i < 7; i++) rc(12'h3e4 + 12'(i * 4), 32'h0);
  endtask
  task reg_access;
    apb(1'b1, 12'h3a8, 8'hff);
    rc(12'h3a8, 32'hff);
    apb(1'b1, 12'h3ac, 8'h5a);
    rc(12'h3ac, 32'h5a);
    apb(1'b1, 12'h3a4, 8'hcb);
    rc(12'h3a4, 32'hcb);
    apb(1'b1, 12'h3e4, 8'hff);
    rc(12'h3e4, 32'h77);
    apb(1'b1, 12'h3a8, 8'h00);
    apb(1'b1, 12'h3ac, 8'h00);
    apb(1'b1, 12'h3a4, 8'h34);
    pstrb <= 4'h0;
    apb(1'b1, 12'h3a8, 8'hff);
    pstrb <= 4'h1;
    rc(12'h3a8, 32'h0);
    rc(12'h000, 32'h0);
    chk(32'(rerr), 32'h1);
  endtask
  task level_channel;
    apb(1'b1, 12'h3e4, 8'h35);
    apb(1'b1, 12'h3a8, 8'h01);
    wt(6);
    apb(1'b1, 12'h3c0, 8'hff);
    rc(12'h3b0, 32'h01);
    chk(32'(pinIntReq), 32'h1);
    apb(1'b1, 12'h3b0, 8'h00);
    rc(12'h3b0, 32'h01);
    want[29] <= 1'b1;
    wt(6);
    rc(12'h3b0, 32'h0);
    chk(32'(pinIntReq), 32'h0);
    apb(1'b1, 12'h3e4, 8'h45);
    apb(1'b1, 12'h3ac, 8'h01);
    wt(6);
    rc(12'h3b0, 32'h0);
    apb(1'b1, 12'h3ac, 8'h00);
  endtask
  task edge_channel;
    slow <= 1'b1;
    apb(1'b1, 12'h3ec, 8'h21);
    apb(1'b1, 12'h3ac, 8'h04);
    apb(1'b1, 12'h3c4, 8'h04);
    apb(1'b1, 12'h3c0, 8'hff);
    want[17] <= 1'b1;
    wt(8);
    rc(12'h3b0, 32'h04);
    rc(12'h3c0, 32'h04);
    chk(32'(irq), 32'h1);
    want[17] <= 1'b0;
    wt(8);
    rc(12'h3b0, 32'h04);
    apb(1'b1, 12'h3c0, 8'h04);
    wt(2);
    chk(32'(irq), 32'h0);
    rc(12'h3c0, 32'h0);
    apb(1'b1, 12'h3b0, 8'h00);
    wt(2);
    rc(12'h3b0, 32'h0);
    chk(32'(pinIntReq), 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    reset_values;
    reg_access;
    level_channel;
    edge_channel;
    complete_run;
  end
endmodule // test_pin_interrupt_unit
`default_nettype wire
